//--- pbw_pkg.sv
// package: power states, wake source indices and timing constants
package pbw_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam longint unsigned LONG_PRESS_MS = 4000;
  localparam longint unsigned LONG_PRESS_CYCLES = (LONG_PRESS_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000000) / CLK_PERIOD_PS;

  // ****************************************
  // power states
  // ****************************************
  typedef enum logic [2:0] {
    PBW_S0 = 3'h0,
    PBW_S1 = 3'h1,
    PBW_S3 = 3'h3,
    PBW_S4 = 3'h4,
    PBW_S5 = 3'h5
  } pbw_state_t;

  // ****************************************
  // wake source indices
  // ****************************************
  localparam int unsigned WK_NET = 0;
  localparam int unsigned WK_PME = 1;
  localparam int unsigned WK_WAKE = 2;
  localparam int unsigned WK_KBMS = 3;
  localparam int unsigned WK_RTC = 4;
  localparam int unsigned WK_SERIAL = 5;
  localparam int unsigned WK_USB = 6;
  localparam int unsigned WK_COUNT = 7;

  // ****************************************
  // reset values of the soft-off wake enables
  // ****************************************
  localparam logic S5_NET_EN_RST = 1'b0;
  localparam logic S5_PME_EN_RST = 1'b0;
  localparam logic S5_KBMS_EN_RST = 1'b0;

endpackage

//--- pbw_press_timer.sv
// module: power switch synchroniser, debouncer and press-length classifier
`timescale 1ns/1ps
module pbw_press_timer #(
  parameter int unsigned DEB_CYCLES = pbw_pkg::DEBOUNCE_CYCLES,
  parameter longint unsigned LONG_CYCLES = pbw_pkg::LONG_PRESS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sw_pressed,
  output logic short_press,
  output logic long_press
);

  localparam int unsigned HW = 34;

  // refused at elaboration: the counters below cannot hold other values
  if (DEB_CYCLES < 1 || LONG_CYCLES < 2 || LONG_CYCLES >= (64'h1 << HW)) begin : g_bad_count
    $error("pbw_press_timer: unsupported count");
  end

  // ****************************************
  // three-stage synchroniser
  // ****************************************
  logic sync1;
  logic sync2;
  logic sync3;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= sw_pressed;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ****************************************
  // debounce
  // ****************************************
  wire agree = (sync2 == sync3);
  logic level;
  logic [31:0] deb_cnt;
  wire deb_done = agree && (sync3 != level) && (deb_cnt >= DEB_CYCLES - 1);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      deb_cnt <= 32'h0;
      level <= 1'b0;
    end else if (!agree || sync3 == level) begin
      deb_cnt <= 32'h0;
    end else if (deb_done) begin
      deb_cnt <= 32'h0;
      level <= sync3;
    end else begin
      deb_cnt <= deb_cnt + 32'h1;
    end
  end

  // ****************************************
  // hold timer
  // ****************************************
  // long press fires at the limit while still held, so a stuck switch still forces off
  logic [HW-1:0] hold_cnt;
  logic long_seen;
  wire press_end = deb_done && !sync3;
  wire hit_long = level && !long_seen && (hold_cnt == HW'(LONG_CYCLES - 1));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt <= {HW{1'b0}};
      long_seen <= 1'b0;
      short_press <= 1'b0;
      long_press <= 1'b0;
    end else begin
      short_press <= press_end && !long_seen;
      long_press <= hit_long;
      if (!level) begin
        hold_cnt <= {HW{1'b0}};
        long_seen <= 1'b0;
      end else if (hit_long) begin
        long_seen <= 1'b1;
      end else if (!long_seen) begin
        hold_cnt <= hold_cnt + {{(HW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

//--- pbw_power_ctrl.sv
// module: system power-state controller with power switch and wake gating
`timescale 1ns/1ps
module pbw_power_ctrl #(
  parameter int unsigned DEB_CYCLES = pbw_pkg::DEBOUNCE_CYCLES,
  parameter longint unsigned LONG_CYCLES = pbw_pkg::LONG_PRESS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sw_pressed,
  input wire logic [pbw_pkg::WK_COUNT-1:0] wake_req,
  input wire logic os_req_valid,
  input wire logic [2:0] os_req_state,
  input wire logic s5_net_en_set,
  input wire logic s5_net_en_clr,
  input wire logic s5_pme_en_set,
  input wire logic s5_pme_en_clr,
  input wire logic s5_kbms_en_set,
  input wire logic s5_kbms_en_clr,
  output logic [2:0] power_state,
  output logic supply_on,
  output logic s5_net_en,
  output logic s5_pme_en,
  output logic s5_kbms_en,
  output logic wake_event
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_sleep(input logic [2:0] s);
    is_sleep = (s == pbw_pkg::PBW_S1) || (s == pbw_pkg::PBW_S3) || (s == pbw_pkg::PBW_S4);
  endfunction

  function automatic logic is_valid(input logic [2:0] s);
    is_valid = (s == pbw_pkg::PBW_S0) || is_sleep(s) || (s == pbw_pkg::PBW_S5);
  endfunction

  // ****************************************
  // switch timing
  // ****************************************
  logic short_press;
  logic long_press;
  pbw_press_timer #(
    .DEB_CYCLES(DEB_CYCLES),
    .LONG_CYCLES(LONG_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .sw_pressed(sw_pressed),
    .short_press(short_press),
    .long_press(long_press)
  );

  // ****************************************
  // wake request synchronisers
  // ****************************************
  logic [pbw_pkg::WK_COUNT-1:0] wk_s1;
  logic [pbw_pkg::WK_COUNT-1:0] wk_s2;
  logic [pbw_pkg::WK_COUNT-1:0] wk_s3;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wk_s1 <= '0;
      wk_s2 <= '0;
      wk_s3 <= '0;
    end else begin
      wk_s1 <= wake_req;
      wk_s2 <= wk_s1;
      wk_s3 <= wk_s2;
    end
  end
  // a request counts only once the second and third stages agree
  wire [pbw_pkg::WK_COUNT-1:0] wk_seen = wk_s2 & wk_s3;

  // ****************************************
  // soft-off wake enables
  // ****************************************
  // set wins over clear on a same-cycle conflict
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s5_net_en <= pbw_pkg::S5_NET_EN_RST;
      s5_pme_en <= pbw_pkg::S5_PME_EN_RST;
      s5_kbms_en <= pbw_pkg::S5_KBMS_EN_RST;
    end else begin
      if (s5_net_en_set) begin
        s5_net_en <= 1'b1;
      end else if (s5_net_en_clr) begin
        s5_net_en <= 1'b0;
      end
      if (s5_pme_en_set) begin
        s5_pme_en <= 1'b1;
      end else if (s5_pme_en_clr) begin
        s5_pme_en <= 1'b0;
      end
      if (s5_kbms_en_set) begin
        s5_kbms_en <= 1'b1;
      end else if (s5_kbms_en_clr) begin
        s5_kbms_en <= 1'b0;
      end
    end
  end

  // ****************************************
  // wake gating table
  // ****************************************
  pbw_pkg::pbw_state_t state;
  wire in_s1 = (state == pbw_pkg::PBW_S1);
  wire in_s3 = (state == pbw_pkg::PBW_S3);
  wire in_s4 = (state == pbw_pkg::PBW_S4);
  wire in_s5 = (state == pbw_pkg::PBW_S5);

  logic [pbw_pkg::WK_COUNT-1:0] wk_allow;
  assign wk_allow[pbw_pkg::WK_NET] = in_s1 || in_s3 || in_s4 || (in_s5 && s5_net_en);
  assign wk_allow[pbw_pkg::WK_PME] = in_s1 || in_s3 || in_s4 || (in_s5 && s5_pme_en);
  assign wk_allow[pbw_pkg::WK_WAKE] = in_s1 || in_s3 || in_s4 || in_s5;
  assign wk_allow[pbw_pkg::WK_KBMS] = in_s1 || in_s3 || (in_s5 && s5_kbms_en);
  assign wk_allow[pbw_pkg::WK_RTC] = in_s3 || in_s4 || in_s5;
  assign wk_allow[pbw_pkg::WK_SERIAL] = in_s3;
  assign wk_allow[pbw_pkg::WK_USB] = in_s3;

  // requests outside their allowed states are simply dropped
  wire wake_hit = |(wk_seen & wk_allow);

  // ****************************************
  // state transitions
  // ****************************************
  wire os_ok = os_req_valid && is_valid(os_req_state);
  pbw_pkg::pbw_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      pbw_pkg::PBW_S0: begin
        if (long_press) begin
          next_state = pbw_pkg::PBW_S5;
        end else if (short_press) begin
          next_state = pbw_pkg::PBW_S1;
        end else if (os_ok) begin
          next_state = pbw_pkg::pbw_state_t'(os_req_state);
        end
      end
      pbw_pkg::PBW_S1, pbw_pkg::PBW_S3, pbw_pkg::PBW_S4: begin
        if (long_press) begin
          next_state = pbw_pkg::PBW_S5;
        end else if (short_press || wake_hit) begin
          next_state = pbw_pkg::PBW_S0;
        end
      end
      pbw_pkg::PBW_S5: begin
        if (short_press || wake_hit) begin
          next_state = pbw_pkg::PBW_S0;
        end
      end
      default: begin
        next_state = pbw_pkg::PBW_S5;
      end
    endcase
  end

  // ****************************************
  // state and outputs
  // ****************************************
  // reset lands in soft-off: the board waits for a short press or a wake that S5 allows
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= pbw_pkg::PBW_S5;
      wake_event <= 1'b0;
    end else begin
      state <= next_state;
      wake_event <= (state != pbw_pkg::PBW_S0) && wake_hit;
    end
  end

  assign power_state = state;
  // supply rails stay up in S0 and S1 only
  assign supply_on = (state == pbw_pkg::PBW_S0) || (state == pbw_pkg::PBW_S1);

endmodule

//--- pbw_far_model.sv
// partner model: front-panel power switch and wake sources
`timescale 1ns/1ps
module pbw_far_model (
  input wire logic core_clk,
  output logic sw_pressed,
  output logic [6:0] wake_req
);
  initial begin
    sw_pressed = 1'b0;
    wake_req = 7'h00;
  end
  // settle after release so that no two presses overlap in the debouncer
  task automatic press(int n);
    @(negedge core_clk) sw_pressed = 1'b1;
    repeat (n) @(negedge core_clk);
    sw_pressed = 1'b0;
    repeat (14) @(negedge core_clk);
  endtask
  task automatic wake(int src, int n);
    @(negedge core_clk) wake_req[src] = 1'b1;
    repeat (n) @(negedge core_clk);
    wake_req[src] = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

//--- pbw_power_checker.sv
// checker: power-state and wake gating properties
`timescale 1ns/1ps
module pbw_power_checker #(
  parameter int unsigned DEB_CYCLES = pbw_pkg::DEBOUNCE_CYCLES,
  parameter longint unsigned LONG_CYCLES = pbw_pkg::LONG_PRESS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sw_pressed,
  input wire logic [pbw_pkg::WK_COUNT-1:0] wake_req,
  input wire logic [2:0] power_state,
  input wire logic supply_on,
  input wire logic s5_net_en,
  input wire logic s5_pme_en,
  input wire logic s5_kbms_en,
  input wire logic wake_event
);
  // ****************
  // switch hold and idle counters
  // ****************
  int hold_cnt;
  int low_cnt;
  always_ff @(posedge core_clk) begin
    hold_cnt <= (sw_pressed && !rst) ? hold_cnt + 1 : 0;
    low_cnt <= (sw_pressed || rst) ? 0 : low_cnt + 1;
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_soft_off: assert property ($fell(rst) |-> power_state == 3'h5 && {s5_net_en, s5_pme_en, s5_kbms_en} == 3'h0)
    else $error("reset state wrong");
  a_supply_follow: assert property (supply_on == (power_state inside {3'h0, 3'h1}))
    else $error("supply enable wrong");
  a_wake_from_sleep: assert property (wake_event |-> $past(power_state) != 3'h0)
    else $error("wake event from working state");
  a_wake_pin_walk: assert property ($rose(wake_req[2]) && power_state != 3'h0 && low_cnt > 12 |-> ##[3:5] power_state == 3'h0)
    else $error("wake pin ignored");
  a_s4_gate: assert property ((power_state == 3'h4 && (wake_req & 7'h17) == 7'h00 && low_cnt > 12)[*8] |=> power_state == 3'h4)
    else $error("disallowed wake left S4");
  a_s5_gate: assert property ((power_state == 3'h5 && {s5_net_en, s5_pme_en, s5_kbms_en} == 3'h0
    && (wake_req & 7'h14) == 7'h00 && low_cnt > 12)[*8] |=> power_state == 3'h5) else $error("disabled wake left S5");
  a_long_off: assert property (hold_cnt == LONG_CYCLES + DEB_CYCLES + 10 |-> power_state == 3'h5)
    else $error("long press did not turn off");
  a_short_wake: assert property ($fell(sw_pressed) && hold_cnt inside {[8:40]} && power_state != 3'h0
    |-> ##[2:14] power_state == 3'h0) else $error("short press did not wake");
  a_short_sleep: assert property ($fell(sw_pressed) && hold_cnt inside {[8:40]} && power_state == 3'h0
    |-> ##[2:14] power_state inside {3'h1, 3'h3, 3'h4}) else $error("short press did not sleep");
  cover property (wake_event);
  cover property (power_state == 3'h4 ##1 power_state == 3'h0);
  cover property (hold_cnt == 62);
endmodule
bind pbw_power_ctrl pbw_power_checker #(.DEB_CYCLES(DEB_CYCLES), .LONG_CYCLES(LONG_CYCLES)) chk_i (.core_clk, .rst,
  .sw_pressed, .wake_req, .power_state, .supply_on, .s5_net_en, .s5_pme_en, .s5_kbms_en, .wake_event);

//--- power_button_wake_control_test.sv
// testbench: power switch, wake gating and soft-off enables
`timescale 1ns/1ps
module power_button_wake_control_test;
  logic core_clk, rst, os_req_valid, supply_on, s5_net_en, s5_pme_en, s5_kbms_en;
  logic wake_event, sw_pressed;
  logic [2:0] os_req_state, set_p, clr_p, power_state, en_exp, st, exp_st;
  logic [2:0] pick [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
  logic [6:0] wake_req;
  int fail_count = 0, n_checks = 0, cyc = 0, n_wake = 0, wk0 = 0;
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  pbw_far_model far (.core_clk, .sw_pressed, .wake_req);
  pbw_power_ctrl #(.DEB_CYCLES(2), .LONG_CYCLES(50)) dut (.core_clk, .rst, .sw_pressed, .wake_req, .os_req_valid,
    .os_req_state, .s5_net_en_set(set_p[2]), .s5_net_en_clr(clr_p[2]), .s5_pme_en_set(set_p[1]),
    .s5_pme_en_clr(clr_p[1]), .s5_kbms_en_set(set_p[0]), .s5_kbms_en_clr(clr_p[0]), .power_state, .supply_on,
    .s5_net_en, .s5_pme_en, .s5_kbms_en, .wake_event);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [2:0] exp, logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic os_req(logic [2:0] s);
    @(negedge core_clk) os_req_valid = 1'b1;
    os_req_state = s;
    @(negedge core_clk) os_req_valid = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  // back to working first: the management request is honoured only there
  task automatic goto(logic [2:0] s);
    if (power_state !== 3'h0) far.press(12);
    os_req(s);
    chk("os request", s, power_state);
  endtask
  function automatic logic [2:0] wake_exp(logic [2:0] s, int src, logic [2:0] en);
    logic [6:0] ok;
    ok = (s == 3'h1) ? 7'h0F : (s == 3'h3) ? 7'h7F : (s == 3'h4) ? 7'h17 : {3'h1, en[0], 1'b1, en[1], en[2]};
    return ok[src] ? 3'h0 : s;
  endfunction
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      print_verdict();
    end
  end
  // wake_event stands one cycle: count it away from the edge that launches it
  always @(negedge core_clk) begin
    if (wake_event !== 1'b0) n_wake++;
  end
  initial begin
    rst = 1'b1;
    os_req_valid = 1'b0;
    os_req_state = 3'h0;
    set_p = 3'h0;
    clr_p = 3'h0;
    en_exp = 3'h0;
    void'($urandom(32'hADDA));
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("reset state", 3'h5, power_state);
    chk("reset enables", 3'h0, {s5_net_en, s5_pme_en, s5_kbms_en});
    far.press(12);
    chk("off short", 3'h0, power_state);
    far.wake(2, 12);
    chk("wake in S0", 3'h0, power_state);
    far.press(2);
    chk("switch glitch", 3'h0, power_state);
    far.press(12);
    chk("on short", 3'h1, {2'h0, power_state inside {3'h1, 3'h3, 3'h4}});
    far.press(12);
    chk("sleep short", 3'h0, power_state);
    os_req(3'h2);
    chk("os bad code", 3'h0, power_state);
    far.press(80);
    chk("on long", 3'h5, power_state);
    far.press(80);
    chk("off long", 3'h5, power_state);
    os_req(3'h0);
    chk("os outside S0", 3'h5, power_state);
    goto(3'h1);
    far.press(80);
    chk("sleep long", 3'h5, power_state);
    for (int i = 0; i < 28; i++) begin
      st = pick[i / 7];
      @(negedge core_clk) set_p = 3'($urandom);
      clr_p = 3'($urandom);
      en_exp = set_p | (en_exp & ~clr_p);
      @(negedge core_clk) set_p = 3'h0;
      clr_p = 3'h0;
      @(negedge core_clk);
      chk("enables", en_exp, {s5_net_en, s5_pme_en, s5_kbms_en});
      goto(st);
      wk0 = n_wake;
      far.wake(i % 7, 8 + int'($urandom % 8));
      exp_st = wake_exp(st, i % 7, en_exp);
      chk("wake gate", exp_st, power_state);
      chk("wake event", {2'h0, exp_st == 3'h0}, 3'(n_wake - wk0));
      chk("supply", {2'h0, exp_st inside {3'h0, 3'h1}}, {2'h0, supply_on});
    end
    // second reset with every soft-off enable set: all must drop again
    @(negedge core_clk) set_p = 3'h7;
    @(negedge core_clk) set_p = 3'h0;
    rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("mid reset state", 3'h5, power_state);
    chk("mid reset enables", 3'h0, {s5_net_en, s5_pme_en, s5_kbms_en});
    print_verdict();
  end
endmodule
